// ==== include/itb_pkg.sv ====
// Shared constants and types for the two-wire byte access target and its controller
package itb_pkg;
  // Pclk timing
  localparam int CLK_NS = 25;
  // Least serial clock low time, applied to both clock halves
  localparam int T_LOW_NS = 1300;
  localparam int SCL_HALF_CYC = (T_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] QTR_LAST = 5'(SCL_HALF_CYC / 2 - 1);

  // Target internal byte space
  localparam int PTR_W = 11;
  localparam int MEM_BYTES = 2048;
  localparam logic [10:0] ADDR_CTRL_CODE = 11'h0e9;
  localparam logic [10:0] ADDR_REG_SEL = 11'h0f4;
  localparam logic [7:0] CTRL_CODE_BYTE_RST = 8'h0e;
  localparam logic [7:0] REG_SEL_BYTE_RST = 8'h00;
  localparam logic [3:0] BIT_COUNT_BYTE = 4'h8;
  localparam logic [3:0] BIT_COUNT_LAST = 4'h7;

  // Controller register map
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_WADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [6:0] CFG_RST = 7'h70;
  localparam int CMD_WRITE_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam logic [2:0] STEP_LAST_WRITE = 3'h4;
  localparam logic [2:0] STEP_LAST_READ = 3'h6;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_CTRL = 3'b001,
    T_WADDR = 3'b010,
    T_WDATA = 3'b011,
    T_ACK = 3'b100,
    T_READ = 3'b101,
    T_RACK = 3'b110,
    T_IGNORE = 3'b111
  } itb_tstate_type;

  typedef enum logic [1:0] {
    S_START = 2'b00,
    S_TX = 2'b01,
    S_RX = 2'b10,
    S_STOP = 2'b11
  } itb_sym_type;
endpackage

// ==== include/itb_if.sv ====
// Open-drain two-wire link between controller and target, with pull-ups
interface itb_if;
  logic scl_out;
  logic scl_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_t_out;
  logic sda_t_oe;
  logic scl_line;
  logic sda_line;

  assign scl_line = (scl_oe && !scl_out) ? 1'b0 : 1'b1;
  assign sda_line = ((sda_m_oe && !sda_m_out) || (sda_t_oe && !sda_t_out)) ? 1'b0 : 1'b1;

  modport master (output scl_out, scl_oe, sda_m_out, sda_m_oe, input sda_line);
  modport target (output sda_t_out, sda_t_oe, input scl_line, sda_line);
endinterface

// ==== logic/itb_bit_sync.sv ====
// Two-flop synchroniser for one pin level
module itb_bit_sync (
  input wire logic clk, // Sampling clock
  input wire logic rst_n, // Async reset, active low
  input wire logic d, // Asynchronous level
  output logic q // Synchronised level
);
  logic meta_r;

  // Idle bus level is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== logic/itb_target.sv ====
// Two-wire target end: control byte decode, byte writes and reads into byte space
// Functional notes
// - Control byte opens and is decoded first
// - Top four bits compared with control code
// - Next three bits are block address
// - Last control bit: one read, zero write
// - Acknowledge control byte on ninth clock
// - Master sends word address after control byte
// - Pointer is block bits joined with word
// - Byte write: three bytes, each acknowledged
// - Data committed when its acknowledge is driven
// - Random read: address write, restart, read
// - Repeated start keeps loaded pointer for read
// - Read byte sent msb first after acknowledge
// - Byte 0xf4 bit zero selects regulator output
// - Default bus address is 0x70
module itb_target (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  itb_if.target link, // Serial bus side
  output logic regulator_select_output, // Virtual input level
  output logic regulator_output_first, // First regulator output enabled
  output logic regulator_output_second // Second regulator output enabled
);
  import itb_pkg::*;

  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  itb_tstate_type state_r;
  itb_tstate_type after_ack_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic [2:0] block_r;
  logic [10:0] ptr_r;
  logic [7:0] tx_r;
  logic sda_oe_r;
  logic master_ack_r;
  logic [7:0] ctrl_code_byte_r;
  logic [7:0] reg_sel_byte_r;
  logic [7:0] mem_r [0:MEM_BYTES-1];
  logic [7:0] rd_byte;
  logic byte_done;
  logic wr_en;

  itb_bit_sync u_scl_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.scl_line),
    .q(scl_s)
  );

  itb_bit_sync u_sda_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.sda_line),
    .q(sda_s)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  // Clock must be high on both samples so a data edge with clock fall is no condition
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det = scl_s && scl_d && !sda_d && sda_s;
  assign byte_done = scl_fall && (cnt_r == BIT_COUNT_BYTE);

  // Commit happens on the same edge that turns the acknowledge on
  assign wr_en = (state_r == T_WDATA) && byte_done;

  always_comb begin
    if (ptr_r == ADDR_CTRL_CODE) begin
      rd_byte = ctrl_code_byte_r;
    end else if (ptr_r == ADDR_REG_SEL) begin
      rd_byte = reg_sel_byte_r;
    end else begin
      rd_byte = mem_r[ptr_r];
    end
  end

  // Bus engine: a start from any state, a stop returns to idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= T_IDLE;
      after_ack_r <= T_IDLE;
      shift_r <= 8'h00;
      cnt_r <= 4'h0;
      block_r <= 3'h0;
      ptr_r <= 11'h000;
      tx_r <= 8'h00;
      sda_oe_r <= 1'b0;
      master_ack_r <= 1'b0;
    end else if (start_det) begin
      // Restart only resets decoding, the pointer stays
      state_r <= T_CTRL;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= T_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        T_CTRL, T_WADDR, T_WDATA: begin
          if (scl_rise && (cnt_r != BIT_COUNT_BYTE)) begin
            shift_r <= {shift_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end else if (byte_done) begin
            cnt_r <= 4'h0;
            if (state_r == T_CTRL) begin
              if (shift_r[7:4] == ctrl_code_byte_r[3:0]) begin
                block_r <= shift_r[3:1];
                sda_oe_r <= 1'b1;
                state_r <= T_ACK;
                after_ack_r <= shift_r[0] ? T_READ : T_WADDR;
              end else begin
                state_r <= T_IGNORE;
              end
            end else if (state_r == T_WADDR) begin
              ptr_r <= {block_r, shift_r};
              sda_oe_r <= 1'b1;
              state_r <= T_ACK;
              after_ack_r <= T_WDATA;
            end else begin
              // Further data bytes land at following addresses
              ptr_r <= ptr_r + 11'h001;
              sda_oe_r <= 1'b1;
              state_r <= T_ACK;
              after_ack_r <= T_WDATA;
            end
          end
        end
        T_ACK: begin
          if (scl_fall) begin
            state_r <= after_ack_r;
            cnt_r <= 4'h0;
            if (after_ack_r == T_READ) begin
              tx_r <= rd_byte;
              sda_oe_r <= !rd_byte[7];
            end else begin
              sda_oe_r <= 1'b0;
            end
          end
        end
        T_READ: begin
          if (scl_fall) begin
            if (cnt_r == BIT_COUNT_LAST) begin
              sda_oe_r <= 1'b0;
              ptr_r <= ptr_r + 11'h001;
              state_r <= T_RACK;
            end else begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_r <= !tx_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        T_RACK: begin
          if (scl_rise) begin
            master_ack_r <= !sda_s;
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            // An acknowledged byte asks for the next one
            if (master_ack_r) begin
              tx_r <= rd_byte;
              sda_oe_r <= !rd_byte[7];
              state_r <= T_READ;
            end else begin
              state_r <= T_IGNORE;
            end
          end
        end
        T_IDLE, T_IGNORE: begin
          sda_oe_r <= 1'b0;
        end
        default: begin
          state_r <= T_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Configuration bytes held in flops so they have a value after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_code_byte_r <= CTRL_CODE_BYTE_RST;
      reg_sel_byte_r <= REG_SEL_BYTE_RST;
    end else if (wr_en) begin
      if (ptr_r == ADDR_CTRL_CODE) begin
        ctrl_code_byte_r <= shift_r;
      end
      if (ptr_r == ADDR_REG_SEL) begin
        reg_sel_byte_r <= shift_r;
      end
    end
  end

  // Plain byte space, not reset: reads before any write return unknown
  always_ff @(posedge pclk) begin
    if (wr_en && (ptr_r != ADDR_CTRL_CODE) && (ptr_r != ADDR_REG_SEL)) begin
      mem_r[ptr_r] <= shift_r;
    end
  end

  assign regulator_select_output = reg_sel_byte_r[0];
  assign regulator_output_first = !reg_sel_byte_r[0];
  assign regulator_output_second = reg_sel_byte_r[0];

  // Open drain: only ever pull low
  assign link.sda_t_out = 1'b0;
  assign link.sda_t_oe = sda_oe_r;
endmodule

// ==== logic/itb_master.sv ====
// Two-wire controller end: runs byte writes and random reads ordered over APB
//
// Decided for this implementation: the APB slave port.
module itb_master (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  itb_if.master link // Serial bus side
);
  import itb_pkg::*;

  logic sda_s;
  logic [6:0] cfg_r;
  logic [7:0] waddr_r;
  logic [7:0] wdata_r;
  logic busy_r;
  logic op_rd_r;
  logic [2:0] step_r;
  logic [3:0] bit_r;
  logic [1:0] q_r;
  logic [4:0] tick_r;
  logic bitin_r;
  logic [7:0] rx_r;
  logic nack_r;
  logic scl_low_r;
  logic sda_low_r;
  logic [31:0] prdata_r;
  itb_sym_type kind;
  logic [7:0] tx_byte;
  logic [2:0] last_step;
  logic qtr_end;
  logic sym_end;
  logic nack_now;
  logic acc;
  logic mapped;
  logic start_wr;
  logic start_rd;
  logic nack_clr;

  itb_bit_sync u_sda_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(link.sda_line),
    .q(sda_s)
  );

  assign acc = psel && penable;
  assign mapped = (paddr == OFS_CFG) || (paddr == OFS_WADDR) || (paddr == OFS_WDATA) ||
                  (paddr == OFS_CMD) || (paddr == OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = prdata_r;
  assign start_wr = acc && pwrite && (paddr == OFS_CMD) && pwdata[CMD_WRITE_BIT] && !busy_r;
  assign start_rd = acc && pwrite && (paddr == OFS_CMD) && pwdata[CMD_READ_BIT] && !busy_r;
  assign nack_clr = acc && pwrite && (paddr == OFS_STATUS) && pwdata[STAT_NACK_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= CFG_RST;
      waddr_r <= 8'h00;
      wdata_r <= 8'h00;
    end else if (acc && pwrite && !busy_r) begin
      if (paddr == OFS_CFG) begin
        cfg_r <= pwdata[6:0];
      end
      if (paddr == OFS_WADDR) begin
        waddr_r <= pwdata[7:0];
      end
      if (paddr == OFS_WDATA) begin
        wdata_r <= pwdata[7:0];
      end
    end
  end

  // Read data latched in the setup cycle, shown in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        OFS_CFG: prdata_r <= {25'h0, cfg_r};
        OFS_WADDR: prdata_r <= {24'h0, waddr_r};
        OFS_WDATA: prdata_r <= {24'h0, wdata_r};
        OFS_STATUS: prdata_r <= {16'h0, rx_r, 6'h0, nack_r, busy_r};
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // Symbol sequence: write S,TX,TX,TX,P; read S,TX,TX,S,TX,RX,P
  always_comb begin
    kind = S_TX;
    tx_byte = 8'h00;
    if (step_r == 3'h0) begin
      kind = S_START;
    end else if (step_r == 3'h1) begin
      tx_byte = {cfg_r, 1'b0};
    end else if (step_r == 3'h2) begin
      tx_byte = waddr_r;
    end else if (step_r == 3'h3) begin
      kind = op_rd_r ? S_START : S_TX;
      tx_byte = wdata_r;
    end else if (step_r == 3'h4) begin
      kind = op_rd_r ? S_TX : S_STOP;
      tx_byte = {cfg_r, 1'b1};
    end else if (step_r == 3'h5) begin
      kind = S_RX;
    end else begin
      kind = S_STOP;
    end
  end

  assign last_step = op_rd_r ? STEP_LAST_READ : STEP_LAST_WRITE;
  assign qtr_end = busy_r && (tick_r == QTR_LAST);
  assign sym_end = qtr_end && (q_r == 2'h3) && (((kind != S_TX) && (kind != S_RX)) ||
                   (bit_r == BIT_COUNT_BYTE));
  assign nack_now = sym_end && (kind == S_TX) && bitin_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_r <= 1'b0;
      op_rd_r <= 1'b0;
      step_r <= 3'h0;
      bit_r <= 4'h0;
      q_r <= 2'h0;
      tick_r <= 5'h00;
      bitin_r <= 1'b0;
      rx_r <= 8'h00;
    end else if (!busy_r) begin
      if (start_wr || start_rd) begin
        busy_r <= 1'b1;
        op_rd_r <= start_rd && !start_wr;
        step_r <= 3'h0;
        bit_r <= 4'h0;
        q_r <= 2'h0;
        tick_r <= 5'h00;
      end
    end else if (!qtr_end) begin
      tick_r <= tick_r + 5'h01;
    end else begin
      tick_r <= 5'h00;
      q_r <= q_r + 2'h1;
      // Sample at the middle of the high half, well after the target has settled
      if (q_r == 2'h2) begin
        bitin_r <= sda_s;
        if ((kind == S_RX) && (bit_r != BIT_COUNT_BYTE)) begin
          rx_r <= {rx_r[6:0], sda_s};
        end
      end
      if (q_r == 2'h3) begin
        if (!sym_end) begin
          bit_r <= bit_r + 4'h1;
        end else begin
          bit_r <= 4'h0;
          if (nack_now) begin
            step_r <= last_step;
          end else if (step_r == last_step) begin
            busy_r <= 1'b0;
          end else begin
            step_r <= step_r + 3'h1;
          end
        end
      end
    end
  end

  // Target refusal is sticky; a new refusal beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nack_r <= 1'b0;
    end else if (nack_now) begin
      nack_r <= 1'b1;
    end else if (nack_clr) begin
      nack_r <= 1'b0;
    end
  end

  // Pin drive, one cycle behind the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else if (!busy_r) begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else begin
      case (kind)
        S_START: begin
          scl_low_r <= (q_r == 2'h0);
          sda_low_r <= q_r[1];
        end
        S_STOP: begin
          scl_low_r <= (q_r == 2'h0);
          sda_low_r <= !q_r[1];
        end
        S_TX: begin
          scl_low_r <= !q_r[1];
          sda_low_r <= (bit_r != BIT_COUNT_BYTE) && !tx_byte[3'(BIT_COUNT_LAST - bit_r)];
        end
        default: begin
          scl_low_r <= !q_r[1];
          sda_low_r <= 1'b0;
        end
      endcase
    end
  end

  assign link.scl_out = 1'b0;
  assign link.scl_oe = scl_low_r;
  assign link.sda_m_out = 1'b0;
  assign link.sda_m_oe = sda_low_r;
endmodule

// ==== verification/itb_link_monitor.sv ====
// Checker for the two-wire link between controller and target
module itb_link_monitor (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic scl_line, // Serial clock level
  input wire logic sda_line, // Serial data level
  input wire logic sda_m_oe, // Controller pulls data
  input wire logic sda_t_oe // Target pulls data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_q_r;
  logic sda_q_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] byte_r;
  logic ign_r;
  logic start_w;
  logic stop_w;
  logic rise_w;

  assign start_w = scl_line && scl_q_r && sda_q_r && !sda_line;
  assign stop_w = scl_line && scl_q_r && !sda_q_r && sda_line;
  assign rise_w = scl_line && !scl_q_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl_line;
      sda_q_r <= sda_line;
    end
  end

  // Bit and byte position since the last start; byte 3 means none yet or the fourth byte onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt_r <= 4'h0;
      byte_r <= 2'h3;
    end else if (start_w) begin
      bit_cnt_r <= 4'h0;
      byte_r <= 2'h0;
    end else if (rise_w && bit_cnt_r == 4'h8) begin
      bit_cnt_r <= 4'h0;
      byte_r <= (byte_r == 2'h3) ? byte_r : byte_r + 2'h1;
    end else if (rise_w) begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // Control byte left unanswered: target stays off until a new start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ign_r <= 1'b0;
    end else if (start_w) begin
      ign_r <= 1'b0;
    end else if (rise_w && byte_r == 2'h0 && bit_cnt_r == 4'h8 && sda_line) begin
      ign_r <= 1'b1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_tgt_moves_low: assert property ($changed(sda_t_oe) |-> !scl_line)
    else $error("target data changed while clock high");
  a_tgt_hold_fall: assert property ($fell(scl_line) |=> $stable(sda_t_oe))
    else $error("target data changed right at clock fall");
  a_ack_stands: assert property ($rose(sda_t_oe) |-> sda_t_oe [*8])
    else $error("target pull too short");
  a_start_by_master: assert property (start_w |-> sda_m_oe && !sda_t_oe)
    else $error("start not made by controller");
  a_ctrl_no_drive: assert property (rise_w && byte_r == 2'h0 && bit_cnt_r < 4'h8 |-> !sda_t_oe)
    else $error("target drove during control byte");
  a_ctrl_master_free: assert property (rise_w && byte_r == 2'h0 && bit_cnt_r == 4'h8 |-> !sda_m_oe)
    else $error("controller held data in acknowledge slot");
  a_nack_ignores: assert property (ign_r |-> !sda_t_oe)
    else $error("target drove after unmatched control byte");
  a_stop_released: assert property (stop_w |-> !sda_t_oe && !sda_m_oe)
    else $error("data still pulled at stop");
endmodule

// ==== verification/i2c_target_byte_access_tb.sv ====
// Bench: controller and target joined over the two-wire link, driven over APB
module i2c_target_byte_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import itb_pkg::*;
  typedef struct {
    logic [2:0] blk;
    logic [7:0] wa;
    logic [7:0] wd;
  } itb_row_type;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic regulator_select_output;
  logic regulator_output_first;
  logic regulator_output_second;
  logic [2:0] outs;
  logic [31:0] rdat;
  logic err;
  int n_fail;
  int checked;
  itb_row_type rows [4];

  itb_if link ();
  itb_master itb_master_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link.master));
  itb_target itb_target_inst (.pclk(pclk), .presetn(presetn), .link(link.target),
    .regulator_select_output(regulator_select_output),
    .regulator_output_first(regulator_output_first),
    .regulator_output_second(regulator_output_second));
  itb_link_monitor itb_link_monitor_inst (.pclk(pclk), .presetn(presetn),
    .scl_line(link.scl_line), .sda_line(link.sda_line), .sda_m_oe(link.sda_m_oe),
    .sda_t_oe(link.sda_t_oe));

  assign outs = {regulator_select_output, regulator_output_first, regulator_output_second};

  always #12.5 pclk = ~pclk;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // One serial command, then poll until idle; status word left in rdat
  task automatic ser(input logic [3:0] code, input logic [2:0] blk, input logic [7:0] wa,
    input logic [7:0] wd, input logic rd);
    apb(1'b1, OFS_CFG, {25'h0, code, blk});
    apb(1'b1, OFS_WADDR, {24'h0, wa});
    apb(1'b1, OFS_WDATA, {24'h0, wd});
    apb(1'b1, OFS_CMD, rd ? 32'h2 : 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    while (rdat[STAT_BUSY_BIT] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Whole sequence needs about 46k cycles; allow 100k
  initial begin
    #(100000 * 25);
    n_fail++;
    give_verdict();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    checked = 0;
    rows = '{'{3'h0, 8'h12, 8'ha5}, '{3'h5, 8'h12, 8'h3c}, '{3'h7, 8'hff, 8'h81},
      '{3'h0, 8'hf4, 8'h01}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg reset", rdat[7:0], 8'h70);
    chk("outputs reset", {5'h0, outs}, 8'h2);
    foreach (rows[i]) begin
      ser(4'he, rows[i].blk, rows[i].wa, rows[i].wd, 1'b0);
      chk("write nack", {7'h0, rdat[STAT_NACK_BIT]}, 8'h0);
    end
    // Same word address in two blocks must give two bytes
    foreach (rows[i]) begin
      ser(4'he, rows[i].blk, rows[i].wa, 8'h00, 1'b1);
      chk("read byte", rdat[15:8], rows[i].wd);
      chk("read nack", {7'h0, rdat[STAT_NACK_BIT]}, 8'h0);
    end
    chk("outputs set", {5'h0, outs}, 8'h5);
    ser(4'h3, 3'h0, 8'h12, 8'h00, 1'b0);
    chk("wrong code nack", {7'h0, rdat[STAT_NACK_BIT]}, 8'h1);
    apb(1'b1, OFS_STATUS, 32'h2);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("nack cleared", {7'h0, rdat[STAT_NACK_BIT]}, 8'h0);
    ser(4'he, 3'h0, 8'h12, 8'h00, 1'b1);
    chk("ignored write", rdat[15:8], 8'ha5);
    // Rewriting the code byte changes the matched code at once
    ser(4'he, 3'h0, 8'he9, 8'h05, 1'b0);
    ser(4'h5, 3'h5, 8'h12, 8'h00, 1'b1);
    chk("new code read", rdat[15:8], 8'h3c);
    ser(4'he, 3'h5, 8'h12, 8'h00, 1'b1);
    chk("old code nack", {7'h0, rdat[STAT_NACK_BIT]}, 8'h1);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped error", {7'h0, err}, 8'h1);
    chk("unmapped data", rdat[7:0], 8'h00);
    // Reset in mid-run restores code and select byte
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("outputs second reset", {5'h0, outs}, 8'h2);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    ser(4'he, 3'h0, 8'hf4, 8'h00, 1'b1);
    chk("select byte reset", rdat[15:8], 8'h00);
    chk("default address", {7'h0, rdat[STAT_NACK_BIT]}, 8'h0);
    give_verdict();
  end
endmodule
